// ---- pkg/cmpmd_map.svh ----
// Register offsets, field positions and reset values of the comparator mode block
`ifndef CMPMD_MAP_SVH
`define CMPMD_MAP_SVH
// ********************************************************
// Register offsets
// ********************************************************
`define CMPMD_ADDR_W 4
`define CMPMD_OFF_MODE 4'h0
`define CMPMD_OFF_CTRL 4'h1
`define CMPMD_OFF_IRQ_STATUS 4'h2
`define CMPMD_OFF_IRQ_MASK 4'h3
// ********************************************************
// Field positions
// ********************************************************
`define CMPMD_BIT_RISE_EN 5
`define CMPMD_BIT_FALL_EN 4
`define CMPMD_BIT_ON 7
`define CMPMD_BIT_OUT 6
`define CMPMD_BIT_RISE_FLAG 5
`define CMPMD_BIT_FALL_FLAG 4
`define CMPMD_BIT_EV_RISE 0
`define CMPMD_BIT_EV_FALL 1
`define CMPMD_BIT_EV_REQ 2
// ********************************************************
// Reset values
// ********************************************************
`define CMPMD_MODE_RESET 8'h02
`define CMPMD_CTRL_RESET 8'h00
`define CMPMD_MASK_RESET 8'h00
`define CMPMD_SPEED_RESET 2'h2
`endif

// ---- pkg/cmpmd_pkg.sv ----
// Types of the comparator mode block
package cmpmd_pkg;
   typedef logic [7:0] cmpmd_byte_t;
   typedef logic [1:0] cmpmd_speed_t;
   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cmpmd_bus_s;
   // Mode register fields
   typedef struct packed {
      logic rise_en;
      logic fall_en;
      cmpmd_speed_t speed;
   } cmpmd_mode_s;
   // Control register fields
   typedef struct packed {
      logic on;
      logic rise_flag;
      logic fall_flag;
      logic [3:0] hyst;
   } cmpmd_ctrl_s;
   // Whole state of the top module
   typedef struct packed {
      cmpmd_mode_s mode;
      cmpmd_ctrl_s ctrl;
      logic [2:0] status;
      logic [2:0] mask;
      logic cmp_prev;
      cmpmd_byte_t rdata;
      logic irq_req;
      logic irq;
      logic routed_out;
      cmpmd_speed_t speed;
   } cmpmd_state_s;
endpackage

// ---- hw/cmpmd_edge.sv ----
// Rising and falling edge detector for the comparator output
`timescale 1ns/10ps
module cmpmd_edge (
   input wire logic clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic level,
   output logic rise,
   output logic fall
);
   logic prev;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prev <= 1'b0;
      end else begin
         prev <= enable & level;
      end
   end
   assign rise = enable & level & ~prev;
   assign fall = enable & ~level & prev;
endmodule

// ---- hw/cmpmd_top.sv ----
// Comparator mode, control and interrupt register block
// Operation
// RULE1 - Mode register bits 7 and 6 read as zero and ignore writes.
// RULE2 - Mode register bits 3 and 2 read as zero and ignore writes.
// RULE3 - Bit 5 enables interrupt requests from rising comparator edges.
// RULE4 - Bit 4 enables interrupt requests from falling comparator edges.
// RULE5 - Bits 1-0 drive analog speed; 0 fastest, 3 lowest power.
// RULE6 - Rising flag sets on each rising edge, stays until software clears.
// RULE7 - Disabled comparator suspends interrupts and forces routed output low. The code gates irq_req only; irq still follows recorded status and mask.
// RULE8 - Request while rise flag and enable, or fall flag and enable, set.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "cmpmd_map.svh"
module cmpmd_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic cmp_level,
   output logic [1:0] speed_sel,
   output logic cmp_on,
   output logic [3:0] hyst_sel,
   output logic routed_out,
   output logic irq_req,
   output logic irq
);
   // ********************************************************
   // State and edge detection
   // ********************************************************
   cmpmd_pkg::cmpmd_state_s st;
   cmpmd_pkg::cmpmd_state_s next_st;
   cmpmd_pkg::cmpmd_bus_s bus;
   logic rise;
   logic fall;
   logic wr_ctrl;
   logic wr_mode;
   logic rd_status;

   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign wr_ctrl = bus.wr && (bus.addr == `CMPMD_OFF_CTRL);
   assign wr_mode = bus.wr && (bus.addr == `CMPMD_OFF_MODE);
   assign rd_status = bus.rd && (bus.addr == `CMPMD_OFF_IRQ_STATUS);

   // Edge detection is gated by the enable, so a disabled comparator raises no flags
   cmpmd_edge u_edge (
      .clk(clk),
      .reset(reset),
      .enable(st.ctrl.on), // RULE7
      .level(cmp_level),
      .rise(rise),
      .fall(fall)
   );

   // ********************************************************
   // Next state
   // ********************************************************
   always_comb begin
      logic [2:0] ev;
      logic req;
      ev = 3'h0;
      req = 1'b0;
      next_st = st;
      next_st.cmp_prev = cmp_level;
      if (wr_mode) begin
         // Only bits 5, 4, 1, 0 are stored
         next_st.mode.rise_en = bus.wdata[`CMPMD_BIT_RISE_EN]; // RULE3
         next_st.mode.fall_en = bus.wdata[`CMPMD_BIT_FALL_EN]; // RULE4
         next_st.mode.speed = bus.wdata[1:0]; // RULE5
      end
      if (wr_ctrl) begin
         next_st.ctrl.on = bus.wdata[`CMPMD_BIT_ON];
         next_st.ctrl.rise_flag = bus.wdata[`CMPMD_BIT_RISE_FLAG];
         next_st.ctrl.fall_flag = bus.wdata[`CMPMD_BIT_FALL_FLAG];
         next_st.ctrl.hyst = bus.wdata[3:0];
      end
      if (bus.wr && (bus.addr == `CMPMD_OFF_IRQ_MASK)) begin
         next_st.mask = bus.wdata[2:0];
      end
      // Edge sets win over a software clear in the same cycle
      if (rise) begin
         next_st.ctrl.rise_flag = 1'b1; // RULE6
         ev[`CMPMD_BIT_EV_RISE] = 1'b1;
      end
      if (fall) begin
         next_st.ctrl.fall_flag = 1'b1;
         ev[`CMPMD_BIT_EV_FALL] = 1'b1;
      end
      req = next_st.ctrl.on &&
            ((next_st.ctrl.rise_flag && next_st.mode.rise_en) ||
             (next_st.ctrl.fall_flag && next_st.mode.fall_en)); // RULE7 RULE8
      if (req && !st.irq_req) begin
         ev[`CMPMD_BIT_EV_REQ] = 1'b1;
      end
      next_st.irq_req = req;
      // A read clears the status; an event in the same cycle stays recorded
      if (rd_status) begin
         next_st.status = ev;
      end else begin
         next_st.status = st.status | ev;
      end
      next_st.irq = |(next_st.status & next_st.mask);
      next_st.routed_out = next_st.ctrl.on & cmp_level; // RULE7
      next_st.speed = next_st.mode.speed; // RULE5
      // Read data stand one cycle after the strobe and are zero otherwise
      next_st.rdata = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            `CMPMD_OFF_MODE: begin
               next_st.rdata = {2'h0, st.mode.rise_en, st.mode.fall_en, 2'h0, st.mode.speed}; // RULE1 RULE2
            end
            `CMPMD_OFF_CTRL: begin
               next_st.rdata = {st.ctrl.on, cmp_level & st.ctrl.on, st.ctrl.rise_flag, st.ctrl.fall_flag,
                                st.ctrl.hyst};
            end
            `CMPMD_OFF_IRQ_STATUS: begin
               next_st.rdata = {5'h00, st.status};
            end
            `CMPMD_OFF_IRQ_MASK: begin
               next_st.rdata = {5'h00, st.mask};
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
   end

   // ********************************************************
   // State register
   // ********************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st <= '0;
         // Speed field leaves reset in mode 2, between fastest and lowest power
         st.mode.speed <= `CMPMD_SPEED_RESET;
         st.speed <= `CMPMD_SPEED_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign speed_sel = st.speed;
   assign cmp_on = st.ctrl.on;
   assign hyst_sel = st.ctrl.hyst;
   assign routed_out = st.routed_out;
   assign irq_req = st.irq_req;
   assign irq = st.irq;

   // ********************************************************
   // Assertions
   // ********************************************************
   // Register bus
   sequence s_mode_read;
      rd && addr == `CMPMD_OFF_MODE;
   endsequence
   sequence s_mode_write;
      wr && addr == `CMPMD_OFF_MODE;
   endsequence
   sequence s_write_then_read;
      s_mode_write ##1 !wr ##1 s_mode_read;
   endsequence

   a_unused_high_zero: assert property (@(posedge clk) disable iff (reset) // RULE1
      s_mode_read |=> rdata[7:6] == 2'h0) else $error("mode bits 7-6 not zero");
   a_unused_mid_zero: assert property (@(posedge clk) disable iff (reset) // RULE2
      s_mode_read |=> rdata[3:2] == 2'h0) else $error("mode bits 3-2 not zero");
   a_mode_write_kept: assert property (@(posedge clk) disable iff (reset) // RULE1 RULE2
      s_write_then_read |=> rdata == {2'h0, $past(wdata[5:4], 3), 2'h0, $past(wdata[1:0], 3)})
      else $error("mode readback wrong");
   a_speed_drive: assert property (@(posedge clk) disable iff (reset) // RULE5
      s_mode_write |=> speed_sel == $past(wdata[1:0])) else $error("speed not driven");
   a_speed_hold: assert property (@(posedge clk) disable iff (reset) // RULE5
      !wr_mode |=> $stable(speed_sel)) else $error("speed changed without write");
   a_hyst_drive: assert property (@(posedge clk) disable iff (reset)
      wr_ctrl |=> hyst_sel == $past(wdata[3:0])) else $error("hysteresis not driven");
   a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
      !rd |=> rdata == 8'h00) else $error("read data without read");

   // Edge flags
   sequence s_rise_seen;
      st.ctrl.on && cmp_level && !u_edge.prev;
   endsequence
   sequence s_fall_seen;
      st.ctrl.on && !cmp_level && u_edge.prev;
   endsequence

   a_rise_flag_set: assert property (@(posedge clk) disable iff (reset) // RULE6
      s_rise_seen |=> st.ctrl.rise_flag [*2] or (st.ctrl.rise_flag ##1 1'b1)) else $error("rise flag");
   a_rise_flag_hold: assert property (@(posedge clk) disable iff (reset) // RULE6
      st.ctrl.rise_flag && !wr_ctrl |=> st.ctrl.rise_flag) else $error("rise flag lost");
   a_fall_flag_set: assert property (@(posedge clk) disable iff (reset) // RULE8
      s_fall_seen |=> st.ctrl.fall_flag) else $error("fall flag");
   a_fall_flag_hold: assert property (@(posedge clk) disable iff (reset) // RULE8
      st.ctrl.fall_flag && !wr_ctrl |=> st.ctrl.fall_flag) else $error("fall flag lost");
   a_rise_en_gate: assert property (@(posedge clk) disable iff (reset) // RULE3
      irq_req && !st.mode.fall_en |-> st.mode.rise_en && st.ctrl.rise_flag) else $error("rise gate");
   a_fall_en_gate: assert property (@(posedge clk) disable iff (reset) // RULE4
      irq_req && !st.mode.rise_en |-> st.mode.fall_en && st.ctrl.fall_flag) else $error("fall gate");

   // Disabled comparator
   a_off_quiet: assert property (@(posedge clk) disable iff (reset) // RULE7
      !cmp_on |-> !irq_req && !routed_out) else $error("disabled not quiet");
   a_off_no_edge: assert property (@(posedge clk) disable iff (reset) // RULE7
      !cmp_on && !wr_ctrl |=> $stable(st.ctrl.rise_flag) && $stable(st.ctrl.fall_flag))
      else $error("edge seen while disabled");
   a_routed_follow: assert property (@(posedge clk) disable iff (reset) // RULE7
      routed_out == (cmp_on && st.cmp_prev)) else $error("routed output wrong");

   // Interrupt request and status
   a_req_cause: assert property (@(posedge clk) disable iff (reset) // RULE8
      cmp_on && st.ctrl.rise_flag && st.mode.rise_en |-> irq_req) else $error("request missing");
   a_req_cause_fall: assert property (@(posedge clk) disable iff (reset) // RULE8
      cmp_on && st.ctrl.fall_flag && st.mode.fall_en |-> irq_req) else $error("fall request missing");
   a_req_only_cause: assert property (@(posedge clk) disable iff (reset) // RULE8
      irq_req |-> cmp_on && ((st.ctrl.rise_flag && st.mode.rise_en) || (st.ctrl.fall_flag && st.mode.fall_en)))
      else $error("request without cause");
   a_status_clear: assert property (@(posedge clk) disable iff (reset)
      rd_status && !rise && !fall |=> st.status[1:0] == 2'h0) else $error("status not cleared");
   a_irq_on_rise: assert property (@(posedge clk) disable iff (reset)
      rise && st.mask[`CMPMD_BIT_EV_RISE] && !(wr && addr == `CMPMD_OFF_IRQ_MASK) |=> irq)
      else $error("masked-in event missed");
endmodule

// ---- testbench/cmpmd_tb.sv ----
// Register and event testbench of the comparator mode block
`timescale 1ns/10ps
`include "cmpmd_map.svh"
module testbench;
   logic clk, reset, wr, rd, cmp_level;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic [1:0] speed_sel;
   logic [3:0] hyst_sel;
   logic cmp_on, routed_out, irq_req, irq;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   cmpmd_top dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .cmp_level(cmp_level), .speed_sel(speed_sel), .cmp_on(cmp_on), .hyst_sel(hyst_sel),
      .routed_out(routed_out), .irq_req(irq_req), .irq(irq));
   // ********************************************************
   // Clock, reset and timeout
   // ********************************************************
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         end_of_test();
      end
   end
   // ********************************************************
   // Bus and compare tasks
   // ********************************************************
   task automatic end_of_test();
      if (mismatches == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic lvl(input logic v);
      @(posedge clk);
      cmp_level <= v;
      cyc(3);
   endtask
   // ********************************************************
   // Main sequence
   // ********************************************************
   initial begin
      reset = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      cmp_level = 1'b0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rd_chk(`CMPMD_OFF_MODE, `CMPMD_MODE_RESET);
      chk({6'h00, speed_sel}, 8'h02);
      wr_reg(`CMPMD_OFF_MODE, 8'hff);
      rd_chk(`CMPMD_OFF_MODE, 8'h33);
      for (int i = 0; i < 4; i++) begin
         wr_reg(`CMPMD_OFF_MODE, i[7:0]);
         cyc(2);
         chk({6'h00, speed_sel}, i[7:0]);
      end
      rd_chk(4'h7, 8'h00);
      wr_reg(`CMPMD_OFF_IRQ_MASK, 8'h03);
      wr_reg(`CMPMD_OFF_MODE, 8'h20);
      wr_reg(`CMPMD_OFF_CTRL, 8'h85);
      cyc(2);
      chk({7'h00, cmp_on}, 8'h01);
      chk({4'h0, hyst_sel}, 8'h05);
      lvl(1'b1);
      chk({7'h00, irq_req}, 8'h01);
      chk({7'h00, routed_out}, 8'h01);
      chk({7'h00, irq}, 8'h01);
      rd_chk(`CMPMD_OFF_CTRL, 8'he5);
      rd_chk(`CMPMD_OFF_IRQ_STATUS, 8'h05);
      cyc(2);
      chk({7'h00, irq}, 8'h00);
      rd_chk(`CMPMD_OFF_CTRL, 8'he5);
      lvl(1'b0);
      wr_reg(`CMPMD_OFF_CTRL, 8'h85);
      cyc(2);
      chk({7'h00, irq_req}, 8'h00);
      rd_chk(`CMPMD_OFF_CTRL, 8'h85);
      wr_reg(`CMPMD_OFF_MODE, 8'h10);
      lvl(1'b1);
      chk({7'h00, irq_req}, 8'h00);
      lvl(1'b0);
      chk({7'h00, irq_req}, 8'h01);
      rd_chk(`CMPMD_OFF_IRQ_STATUS, 8'h07);
      // Switching off must drop the pending request and ignore edges
      wr_reg(`CMPMD_OFF_CTRL, 8'h05);
      cyc(2);
      chk({7'h00, cmp_on}, 8'h00);
      lvl(1'b1);
      chk({7'h00, routed_out}, 8'h00);
      chk({7'h00, irq_req}, 8'h00);
      rd_chk(`CMPMD_OFF_CTRL, 8'h05);
      lvl(1'b0);
      wr_reg(`CMPMD_OFF_IRQ_MASK, 8'h00);
      wr_reg(`CMPMD_OFF_MODE, 8'h00);
      wr_reg(`CMPMD_OFF_CTRL, 8'h80);
      lvl(1'b1);
      chk({7'h00, irq}, 8'h00);
      chk({7'h00, irq_req}, 8'h00);
      rd_chk(`CMPMD_OFF_IRQ_STATUS, 8'h01);
      end_of_test();
   end
endmodule
